// *** verilog/dxcfg_top.sv ***
// Top: extended configuration words of a DDR2 device, loaded by load-mode.
// Assumes the controller keeps idle banks, gaps and reserved-bit zeros.
// Functional notes
// R1: Controller loads word one only with banks idle, then waits the gap.
// R2: Word one keeps its value until the next load-mode or power loss.
// R3: Delay-locked loop follows dll_off_bit captured at load-mode.
// R4: Loop off in self refresh, re-enabled and reset on exit.
// R5: Controller waits 200 cycles after loop reset before a read.
// R6: Controller should follow loop enable with a loop reset.
// R7: Below 25 MHz with loop off, precharge all follows refresh.
// R8: weak_drive_bit selects full or reduced output drive.
// R9: Complement strobe per strobe_complement_off_bit; read strobe complement needs both.
// R10: Read strobe mirrors data strobe on reads, ignored on writes.
// R11: output_off_bit disables data and strobe outputs.
// R12: Termination value 50, 75 or 150 ohms on all data signals.
// R13: ODT pin switches termination only if enabled and in allowed states.
// R14: Controller turns ODT off before self refresh entry.
// R15: Controller keeps ODT low eight cycles after termination enable.
// R16: Controller writes driver calibration bits ones then zeros.
// R17: Additive latency from posted_latency_field, 0 to 6 cycles.
// R18: Reads and writes held internally for the additive latency.
// R19: Read data starts at additive plus CAS latency.
// R20: Write data captured at read latency minus one.
// R21: Word two holds only hot_refresh_rate_bit.
// R22: Controller writes zeros above address bit twelve and bank bit two.
// R23: Termination pair: 00 off, 01 75, 10 150, 11 50 ohms.
// R24: Word one selected by bank bits 01.
// R25: Word two selected by bank bits 10.
`timescale 1ns/1ps
module dxcfg_top #(
  parameter int ADDR_W = 13,
  parameter logic [2:0] CAS_LATENCY = 3'h3,
  parameter bit WIDE_X8 = 1'b1
) (
  input wire logic clk_in, // Device clock
  input wire logic sys_rst_in, // Async reset, high
  input wire logic cmd_valid_in, // Command strobe
  input wire logic [2:0] cmd_code_in, // Command code
  input wire logic [1:0] bank_in, // Bank address
  input wire logic [ADDR_W-1:0] addr_in, // Address bus
  input wire logic self_refresh_in, // Device in self refresh
  input wire logic odt_state_ok_in, // Active or power-down state
  input wire logic odt_in, // ODT pin
  output logic dll_enable_out, // Loop running
  output logic dll_reset_out, // Loop reset pulse
  output logic weak_drive_out, // Reduced drive
  output logic dqs_n_enable_out, // Complement strobe on
  output logic rdqs_enable_out, // Read strobe on
  output logic rdqs_n_enable_out, // Read strobe complement on
  output logic outputs_off_out, // Outputs disabled
  output dxcfg_pkg::dxcfg_term_t term_value_out, // Termination value
  output logic term_active_out, // Termination applied
  output logic [2:0] add_latency_out, // Additive latency
  output logic hot_refresh_out, // Faster refresh
  output logic read_issue_out, // Internal read issue
  output logic write_issue_out, // Internal write issue
  output logic read_data_start_out, // First read data cycle
  output logic write_capture_out // Write data capture cycle
);
  // ****************************************
  // Command decode
  // ****************************************
  logic load_cmd;
  logic load_one;
  logic load_two;
  logic read_cmd;
  logic write_cmd;
  assign load_cmd = cmd_valid_in && (cmd_code_in == dxcfg_pkg::CMD_LOAD_MODE);
  assign read_cmd = cmd_valid_in && (cmd_code_in == dxcfg_pkg::CMD_READ);
  assign write_cmd = cmd_valid_in && (cmd_code_in == dxcfg_pkg::CMD_WRITE);
  // R24: word one select
  assign load_one = load_cmd && (bank_in == dxcfg_pkg::BANK_WORD_ONE);
  // R25: word two select
  assign load_two = load_cmd && (bank_in == dxcfg_pkg::BANK_WORD_TWO);
  // ****************************************
  // Configuration words
  // ****************************************
  logic [12:0] word_one_q;
  logic [12:0] word_one_d;
  logic hot_q;
  logic hot_d;
  // R2: hold until next load
  assign word_one_d = load_one ? addr_in[12:0] : word_one_q;
  // R21: only refresh bit kept
  assign hot_d = load_two ? addr_in[dxcfg_pkg::POS_HOT_REFRESH] : hot_q;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      word_one_q <= dxcfg_pkg::WORD_ONE_RESET;
      hot_q <= dxcfg_pkg::WORD_TWO_RESET[dxcfg_pkg::POS_HOT_REFRESH];
    end else begin
      word_one_q <= word_one_d;
      hot_q <= hot_d;
    end
  end
  // ****************************************
  // Field decode
  // ****************************************
  logic dll_off;
  logic strobe_comp_off;
  logic read_strobe_on;
  logic out_off;
  logic [2:0] lat_field;
  logic [2:0] lat_eff;
  dxcfg_pkg::dxcfg_term_t term_sel;
  assign dll_off = word_one_q[dxcfg_pkg::POS_DLL_OFF];
  assign strobe_comp_off = word_one_q[dxcfg_pkg::POS_STROBE_COMP_OFF];
  assign read_strobe_on = word_one_q[dxcfg_pkg::POS_READ_STROBE_ON] && WIDE_X8;
  assign out_off = word_one_q[dxcfg_pkg::POS_OUTPUT_OFF];
  // R17: latency field, reserved clamped
  assign lat_field = word_one_q[dxcfg_pkg::POS_LATENCY_LO +: 3];
  assign lat_eff = (lat_field > dxcfg_pkg::LATENCY_MAX) ? dxcfg_pkg::LATENCY_MAX : lat_field;
  // R23: termination pair decode
  assign term_sel = dxcfg_pkg::dxcfg_term_t'({word_one_q[dxcfg_pkg::POS_TERM_HIGH],
                                               word_one_q[dxcfg_pkg::POS_TERM_LOW]});
  // ****************************************
  // Delay-locked loop control
  // ****************************************
  logic sr_q;
  logic dll_en_d;
  logic dll_rst_d;
  logic sr_exit;
  logic load_enables;
  assign sr_exit = sr_q && !self_refresh_in;
  assign load_enables = load_one && !addr_in[dxcfg_pkg::POS_DLL_OFF] && dll_off;
  // R3: follow captured loop bit; R4: off in self refresh
  assign dll_en_d = !self_refresh_in && !word_one_d[dxcfg_pkg::POS_DLL_OFF];
  // R4: reset on self refresh exit
  assign dll_rst_d = (sr_exit && !dll_off) || load_enables;
  // ****************************************
  // Output pin controls
  // ****************************************
  logic dqs_n_d;
  logic rdqs_n_d;
  logic term_act_d;
  // R9: complement strobe enables
  assign dqs_n_d = !strobe_comp_off && !out_off;
  assign rdqs_n_d = read_strobe_on && !strobe_comp_off && !out_off;
  // R13: ODT gated by enable and state; R12: applied to all data signals
  assign term_act_d = (term_sel != dxcfg_pkg::DXCFG_TERM_OFF) && odt_state_ok_in && odt_in;
  // ****************************************
  // Latency timing
  // ****************************************
  dxcfg_lat_if rd_hold ();
  dxcfg_lat_if wr_hold ();
  dxcfg_lat_if rd_data ();
  dxcfg_lat_if wr_data ();
  // R18: hold commands for additive latency
  assign rd_hold.start = read_cmd;
  assign rd_hold.delay = {1'b0, lat_eff};
  assign wr_hold.start = write_cmd;
  assign wr_hold.delay = {1'b0, lat_eff};
  // R19: read latency equals additive plus CAS
  assign rd_data.start = read_cmd;
  assign rd_data.delay = 4'({1'b0, lat_eff} + {1'b0, CAS_LATENCY});
  // R20: write latency one less than read
  assign wr_data.start = write_cmd;
  assign wr_data.delay = 4'({1'b0, lat_eff} + {1'b0, CAS_LATENCY} - 4'h1);
  // Output register adds one cycle to every pulse
  dxcfg_delay #(.DEPTH(16)) u_rd_hold (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .lat(rd_hold));
  dxcfg_delay #(.DEPTH(16)) u_wr_hold (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .lat(wr_hold));
  dxcfg_delay #(.DEPTH(16)) u_rd_data (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .lat(rd_data));
  dxcfg_delay #(.DEPTH(16)) u_wr_data (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .lat(wr_data));
  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sr_q <= 1'b0;
      dll_enable_out <= 1'b0;
      dll_reset_out <= 1'b0;
      weak_drive_out <= 1'b0;
      dqs_n_enable_out <= 1'b0;
      rdqs_enable_out <= 1'b0;
      rdqs_n_enable_out <= 1'b0;
      outputs_off_out <= 1'b0;
      term_value_out <= dxcfg_pkg::DXCFG_TERM_OFF;
      term_active_out <= 1'b0;
      add_latency_out <= 3'h0;
      hot_refresh_out <= 1'b0;
      read_issue_out <= 1'b0;
      write_issue_out <= 1'b0;
      read_data_start_out <= 1'b0;
      write_capture_out <= 1'b0;
    end else begin
      sr_q <= self_refresh_in;
      dll_enable_out <= dll_en_d;
      dll_reset_out <= dll_rst_d;
      // R8: drive strength select
      weak_drive_out <= word_one_q[dxcfg_pkg::POS_WEAK_DRIVE];
      dqs_n_enable_out <= dqs_n_d;
      // R10: read strobe from its bit on x8 parts, for any command; R11: outputs off
      rdqs_enable_out <= read_strobe_on && !out_off;
      rdqs_n_enable_out <= rdqs_n_d;
      outputs_off_out <= out_off;
      term_value_out <= term_sel;
      term_active_out <= term_act_d;
      add_latency_out <= lat_eff;
      hot_refresh_out <= hot_q;
      read_issue_out <= rd_hold.fire;
      write_issue_out <= wr_hold.fire;
      read_data_start_out <= rd_data.fire;
      write_capture_out <= wr_data.fire;
    end
  end
endmodule : dxcfg_top

// *** verilog/dxcfg_pkg.sv ***
// Package: extended mode configuration constants for the DDR2 device model.
// Assumes bank address and address bits are sampled on the device clock.
package dxcfg_pkg;
  // ****************************************
  // Command and bank decode
  // ****************************************
  localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [1:0] BANK_WORD_ONE = 2'h1;
  localparam logic [1:0] BANK_WORD_TWO = 2'h2;
  localparam int WORD_W = 13;
  // ****************************************
  // Field positions of word one, and the refresh bit of word two
  // ****************************************
  localparam int POS_DLL_OFF = 0;
  localparam int POS_WEAK_DRIVE = 1;
  localparam int POS_TERM_LOW = 2;
  localparam int POS_LATENCY_LO = 3;
  localparam int POS_TERM_HIGH = 6;
  localparam int POS_STROBE_COMP_OFF = 10;
  localparam int POS_READ_STROBE_ON = 11;
  localparam int POS_OUTPUT_OFF = 12;
  localparam int POS_HOT_REFRESH = 7;
  localparam logic [2:0] LATENCY_MAX = 3'h6;
  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [12:0] WORD_ONE_RESET = 13'h0000;
  localparam logic [12:0] WORD_TWO_RESET = 13'h0000;
  localparam int DLL_LOCK_CYCLES = 200;
  // ****************************************
  // Termination encoding
  // ****************************************
  typedef enum logic [1:0] {
    DXCFG_TERM_OFF = 2'h0,
    DXCFG_TERM_75 = 2'h1,
    DXCFG_TERM_150 = 2'h2,
    DXCFG_TERM_50 = 2'h3
  } dxcfg_term_t;
endpackage : dxcfg_pkg

// *** verilog/dxcfg_lat_if.sv ***
// Interface: latency request and strobe between top and delay line.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface dxcfg_lat_if;
  logic start;
  logic [3:0] delay;
  logic fire;
  modport src (output start, output delay, input fire);
  modport dly (input start, input delay, output fire);
endinterface : dxcfg_lat_if

// *** verilog/dxcfg_delay.sv ***
// Delay line: fires a pulse a programmable number of cycles after start.
// Assumes start pulses are one cycle wide; overlapping requests are queued by shift.
`timescale 1ns/1ps
module dxcfg_delay #(
  parameter int DEPTH = 16
) (
  input wire logic clk_in, // Clock
  input wire logic sys_rst_in, // Async reset
  dxcfg_lat_if.dly lat // Request and strobe
);
  logic [DEPTH-1:0] pipe_q;
  logic [DEPTH-1:0] pipe_d;
  logic [DEPTH-1:0] inject;
  assign inject = lat.start ? (DEPTH'(1) << lat.delay) : '0;
  assign pipe_d = (pipe_q >> 1) | inject;
  assign lat.fire = pipe_q[0];
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) pipe_q <= '0;
    else pipe_q <= pipe_d;
  end
endmodule : dxcfg_delay

// *** tb/dxcfg_sva.sv ***
// Checker: port relations of the extended configuration block.
// Assumes one clock and a controller that leaves a gap after each load.
`timescale 1ns/1ps
module dxcfg_sva #(
  parameter int ADDR_W = 13,
  parameter logic [2:0] CAS_LATENCY = 3'h3
) (
  input wire logic clk_in, // Clock
  input wire logic sys_rst_in, // Reset
  input wire logic cmd_valid_in, // Strobe
  input wire logic [2:0] cmd_code_in, // Code
  input wire logic [1:0] bank_in, // Bank
  input wire logic [ADDR_W-1:0] addr_in, // Mode bits
  input wire logic self_refresh_in, // Self refresh
  input wire logic odt_state_ok_in, // ODT state
  input wire logic odt_in, // ODT pin
  input wire logic dll_enable_out, // Loop on
  input wire logic dll_reset_out, // Loop reset
  input wire logic weak_drive_out, // Drive
  input wire logic dqs_n_enable_out, // Strobe complement
  input wire logic rdqs_enable_out, // Read strobe
  input wire logic rdqs_n_enable_out, // Read strobe complement
  input wire logic outputs_off_out, // Outputs off
  input wire dxcfg_pkg::dxcfg_term_t term_value_out, // Termination
  input wire logic term_active_out, // Termination on
  input wire logic [2:0] add_latency_out, // Additive latency
  input wire logic hot_refresh_out, // Fast refresh
  input wire logic read_issue_out, // Read issue
  input wire logic read_data_start_out, // Read data
  input wire logic write_issue_out, // Write issue
  input wire logic write_capture_out // Write capture
);
  localparam int CLI = CAS_LATENCY;
  localparam int WLI = CLI - 1;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence ld_one;
    cmd_valid_in && cmd_code_in == dxcfg_pkg::CMD_LOAD_MODE && bank_in == dxcfg_pkg::BANK_WORD_ONE ##1 !cmd_valid_in;
  endsequence
  sequence ld_two;
    cmd_valid_in && cmd_code_in == dxcfg_pkg::CMD_LOAD_MODE && bank_in == dxcfg_pkg::BANK_WORD_TWO ##1 !cmd_valid_in;
  endsequence
  a_weak_drive: assert property (ld_one |-> ##1 weak_drive_out == $past(addr_in[1], 2))
    else $error("drive strength not loaded");
  a_term_decode: assert property (ld_one |-> ##1 term_value_out == {$past(addr_in[6], 2), $past(addr_in[2], 2)})
    else $error("termination code not loaded");
  a_latency_clamp: assert property (ld_one |-> ##1
    add_latency_out == (($past(addr_in[5:3], 2) == 3'h7) ? 3'h6 : $past(addr_in[5:3], 2)))
    else $error("additive latency wrong");
  a_hot_refresh: assert property (ld_two |-> ##1 hot_refresh_out == $past(addr_in[7], 2))
    else $error("refresh rate bit wrong");
  a_outputs_off: assert property (outputs_off_out |-> !dqs_n_enable_out && !rdqs_enable_out && !rdqs_n_enable_out)
    else $error("strobe on while outputs off");
  a_rdqs_n_gate: assert property (rdqs_n_enable_out |-> rdqs_enable_out && dqs_n_enable_out)
    else $error("read strobe complement ungated");
  a_term_gate: assert property (term_active_out |->
    $past(odt_in) && $past(odt_state_ok_in) && term_value_out != dxcfg_pkg::DXCFG_TERM_OFF)
    else $error("termination on without pin");
  a_read_issue: assert property (cmd_valid_in && cmd_code_in == dxcfg_pkg::CMD_READ && add_latency_out == 3'h0
    |-> ##2 read_issue_out)
    else $error("read not issued");
  a_read_data: assert property (read_issue_out |-> ##CLI read_data_start_out)
    else $error("read data late");
  a_write_cap: assert property (write_issue_out |-> ##WLI write_capture_out)
    else $error("write capture late");
  a_dll_sref: assert property (self_refresh_in |=> !dll_enable_out)
    else $error("loop on in self refresh");
  a_dll_load: assert property (ld_one ##0 !$past(self_refresh_in) |-> dll_enable_out == !$past(addr_in[0]))
    else $error("loop enable not loaded");
  a_sref_reset: assert property (!cmd_valid_in && $past(self_refresh_in) && !self_refresh_in
    |=> dll_reset_out == dll_enable_out)
    else $error("loop reset missing on self refresh exit");
endmodule : dxcfg_sva

// *** tb/dxcfg_ctl.sv ***
// Controller model: drives command, bank, mode bits and ODT on falling edges.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
module dxcfg_ctl (
  input wire logic clk_in, // Clock
  output logic cmd_valid_in, // Strobe
  output logic [2:0] cmd_code_in, // Code
  output logic [1:0] bank_in, // Bank
  output logic [12:0] addr_in, // Mode bits
  output logic odt_in // ODT pin
);
  initial begin
    cmd_valid_in = 1'b0;
    cmd_code_in = 3'h7;
    bank_in = 2'h3;
    addr_in = 13'h1555;
    odt_in = 1'b0;
  end
  // only 13 mode bits, bank chosen by caller
  task automatic issue(input logic [2:0] code, input logic [1:0] bank, input logic [12:0] addr);
    @(negedge clk_in);
    cmd_valid_in = 1'b1;
    cmd_code_in = code;
    bank_in = bank;
    addr_in = addr;
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    cmd_code_in = ~code;
    bank_in = ~bank;
    addr_in = ~addr;
  endtask : issue
  // ODT low, gap and eight idle cycles after a load
  task automatic load(input logic [1:0] bank, input logic [12:0] addr, input logic odt);
    odt_in = 1'b0;
    issue(dxcfg_pkg::CMD_LOAD_MODE, bank, addr);
    repeat (8) @(negedge clk_in);
    odt_in = odt;
    repeat (2) @(negedge clk_in);
  endtask : load
endmodule : dxcfg_ctl

// *** tb/dxcfg_top_tb.sv ***
// Testbench: loads both extended words and checks decoded outputs and latencies.
// Assumes the default CAS latency of 3 and an x8 part.
`timescale 1ns/1ps
module dxcfg_top_tb;
  localparam int CL = 3;
  logic clk_in, sys_rst_in, cmd_valid_in, self_refresh_in, odt_state_ok_in, odt_in;
  logic [2:0] cmd_code_in;
  logic [1:0] bank_in;
  logic [12:0] addr_in;
  logic dll_enable_out, dll_reset_out, weak_drive_out, dqs_n_enable_out, rdqs_enable_out, rdqs_n_enable_out;
  logic outputs_off_out, term_active_out, hot_refresh_out, read_issue_out, read_data_start_out;
  logic write_issue_out, write_capture_out;
  logic [2:0] add_latency_out;
  dxcfg_pkg::dxcfg_term_t term_value_out;
  int errors;
  int n_tests;
  dxcfg_top #(.CAS_LATENCY(3'h3)) dut_u (.*);
  dxcfg_ctl ctl_u (.*);
  task automatic chk(input string what, input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic pick(input int s);
    case (s)
      0: return read_issue_out;
      1: return read_data_start_out;
      2: return write_issue_out;
      3: return write_capture_out;
      default: return dll_reset_out;
    endcase
  endfunction : pick
  // Cycles until the chosen pulse shows
  task automatic first(input int s, output int k);
    k = 0;
    while (pick(s) !== 1'b1 && k < 20) begin
      @(negedge clk_in);
      k++;
    end
  endtask : first
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    finish_test();
  end
  initial begin
    int i, j, k, m;
    logic [12:0] a;
    logic [1:0] t;
    errors = 0;
    n_tests = 0;
    sys_rst_in = 1'b1;
    self_refresh_in = 1'b0;
    odt_state_ok_in = 1'b0;
    repeat (10) @(negedge clk_in);
    sys_rst_in = 1'b0;
    @(negedge clk_in);
    chk("reset", {dll_enable_out, term_value_out, add_latency_out, hot_refresh_out}, 13'h40);
    ctl_u.load(dxcfg_pkg::BANK_WORD_ONE, 13'h0380, 1'b0);
    ctl_u.load(dxcfg_pkg::BANK_WORD_ONE, 13'h0000, 1'b0);
    $display("test reset done");
    for (i = 0; i < 64; i++) begin
      a = {i[5], i[4], i[3], 3'h0, i[2], 3'h0, i[1], i[0], 1'b0};
      odt_state_ok_in = ~i[0];
      ctl_u.load(dxcfg_pkg::BANK_WORD_ONE, a, 1'b1);
      t = {a[6], a[2]};
      chk("outs", {weak_drive_out, dqs_n_enable_out, rdqs_enable_out,
        rdqs_n_enable_out, outputs_off_out, term_value_out, term_active_out}, {a[1], !a[10] && !a[12],
        a[11] && !a[12], a[11] && !a[10] && !a[12], a[12], t, t != 2'h0 && !a[1]});
    end
    $display("test fields done");
    ctl_u.load(dxcfg_pkg::BANK_WORD_TWO, 13'h1fff, 1'b0);
    chk("word two", {hot_refresh_out, weak_drive_out, outputs_off_out}, 13'h7);
    ctl_u.load(2'h3, 13'h0000, 1'b0);
    chk("other bank", {hot_refresh_out, weak_drive_out, outputs_off_out}, 13'h7);
    ctl_u.load(dxcfg_pkg::BANK_WORD_TWO, 13'h1f7f, 1'b0);
    chk("refresh off", {hot_refresh_out, weak_drive_out}, 13'h1);
    $display("test words done");
    ctl_u.load(dxcfg_pkg::BANK_WORD_ONE, 13'h0001, 1'b0);
    chk("loop off", dll_enable_out, 1'b0);
    ctl_u.load(dxcfg_pkg::BANK_WORD_ONE, 13'h0000, 1'b0);
    chk("loop on", dll_enable_out, 1'b1);
    // ODT already low before self refresh
    self_refresh_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk("sref loop", dll_enable_out, 1'b0);
    self_refresh_in = 1'b0;
    first(4, k);
    chk("loop reset", 13'(k), 13'h1);
    chk("loop back", dll_enable_out, 1'b1);
    repeat (dxcfg_pkg::DLL_LOCK_CYCLES) @(negedge clk_in);
    $display("test loop done");
    for (j = 0; j < 8; j++) begin
      ctl_u.load(dxcfg_pkg::BANK_WORD_ONE, 13'(j << 3), 1'b0);
      chk("latency", add_latency_out, 13'((j > 6) ? 6 : j));
      ctl_u.issue(dxcfg_pkg::CMD_READ, 2'h0, 13'h0000);
      first(0, k);
      first(1, m);
      chk("read issue", 13'(k), 13'(((j > 6) ? 6 : j) + 1));
      chk("read data", 13'(m), 13'(CL));
      ctl_u.issue(dxcfg_pkg::CMD_WRITE, 2'h0, 13'h0000);
      first(2, k);
      first(3, m);
      chk("write issue", 13'(k), 13'(((j > 6) ? 6 : j) + 1));
      chk("write capture", 13'(m), 13'(CL - 1));
    end
    $display("test latency done");
    finish_test();
  end
endmodule : dxcfg_top_tb
bind dxcfg_top dxcfg_sva #(.ADDR_W(ADDR_W), .CAS_LATENCY(CAS_LATENCY)) sva_u (.*);
